// ==== program_counter_sequencer.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Program counter is 10 bits, covering all 1K program words.
// - Reset loads the counter with entry address 0x000.
// - Software interrupt redirects the counter to 0x001 when no hardware interrupt is taken.
// - Any hardware interrupt redirects the counter to 0x008.
// - Short call, in-page jump and call reach a 256-location window.
// - Plain jump reaches a 512-location range.
// - Long call and long jump reach any program address.
// - Calls and interrupts push the next address on the stack.
// - All three returns pop the stack top into the counter.
// - Rolling-code words 0x00E-0x00F fetch like ordinary words.
// - One cycle per instruction; taken branches and skips take two.
module program_counter_sequencer (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cycle_en,
   input wire pc_seq_pkg::flow_req_t flow_req,
   input wire logic soft_int_take,
   input wire logic hw_int_take,
   output logic [pc_seq_pkg::PC_W-1:0] fetch_addr_ff,
   output logic flush_ff,
   output logic [pc_seq_pkg::SP_W-1:0] stack_ptr_ff,
   output logic reserved_fetch_ff
);
   logic [pc_seq_pkg::PC_W-1:0] pc_ff;
   logic [pc_seq_pkg::PC_W-1:0] nxt_pc;
   logic [pc_seq_pkg::PC_W-1:0] pc_inc;
   logic [pc_seq_pkg::PC_W-1:0] stack_mem [pc_seq_pkg::STACK_DEPTH];
   logic [pc_seq_pkg::SP_W-1:0] nxt_sp;
   logic [pc_seq_pkg::SP_W-1:0] top_idx;
   logic do_push;
   logic do_pop;
   logic redirect;
   logic bubble_ff;

   assign pc_inc = pc_ff + pc_seq_pkg::PC_STEP;
   assign top_idx = stack_ptr_ff - 3'h1;

   // Second cycle of a taken branch or skip executes nothing
   always_comb begin
      nxt_pc = pc_inc;
      do_push = 1'b0;
      do_pop = 1'b0;
      redirect = 1'b0;
      if (hw_int_take) begin
         nxt_pc = pc_seq_pkg::VEC_HW_INT;
         do_push = 1'b1;
         redirect = 1'b1;
      end else if (soft_int_take) begin
         nxt_pc = pc_seq_pkg::VEC_SOFT_INT;
         do_push = 1'b1;
         redirect = 1'b1;
      end else if (!bubble_ff) begin
         case (flow_req.op)
            pc_seq_pkg::OP_SHORT_CALL,
            pc_seq_pkg::OP_CALL_IN_PAGE: begin
               nxt_pc = {pc_ff[9:8], flow_req.target[7:0]};
               do_push = 1'b1;
               redirect = 1'b1;
            end
            pc_seq_pkg::OP_JUMP_IN_PAGE: begin
               nxt_pc = {pc_ff[9:8], flow_req.target[7:0]};
               redirect = 1'b1;
            end
            pc_seq_pkg::OP_JUMP: begin
               nxt_pc = {pc_ff[9], flow_req.target[8:0]};
               redirect = 1'b1;
            end
            pc_seq_pkg::OP_LONG_CALL: begin
               nxt_pc = flow_req.target;
               do_push = 1'b1;
               redirect = 1'b1;
            end
            pc_seq_pkg::OP_LONG_JUMP: begin
               nxt_pc = flow_req.target;
               redirect = 1'b1;
            end
            pc_seq_pkg::OP_RETURN,
            pc_seq_pkg::OP_RETURN_WITH_LITERAL,
            pc_seq_pkg::OP_RETURN_FROM_INTERRUPT: begin
               nxt_pc = stack_mem[top_idx];
               do_pop = 1'b1;
               redirect = 1'b1;
            end
            pc_seq_pkg::OP_SKIP: begin
               redirect = flow_req.skip_taken;
            end
            default: begin
               nxt_pc = pc_inc;
            end
         endcase
      end
   end

   // Pointer wraps: ninth push lands on the oldest slot, no flag
   always_comb begin
      nxt_sp = stack_ptr_ff;
      if (do_push) begin
         nxt_sp = stack_ptr_ff + 3'h1;
      end else if (do_pop) begin
         nxt_sp = top_idx;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pc_ff <= pc_seq_pkg::VEC_RESET;
      end else if (cycle_en) begin
         pc_ff <= nxt_pc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (cycle_en && do_push) begin
         stack_mem[stack_ptr_ff] <= pc_inc;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stack_ptr_ff <= '0;
      end else if (cycle_en) begin
         stack_ptr_ff <= nxt_sp;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bubble_ff <= 1'b0;
         flush_ff <= 1'b0;
      end else if (cycle_en) begin
         bubble_ff <= redirect && !bubble_ff;
         flush_ff <= redirect && !bubble_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fetch_addr_ff <= pc_seq_pkg::VEC_RESET;
         reserved_fetch_ff <= 1'b0;
      end else if (cycle_en) begin
         fetch_addr_ff <= nxt_pc;
         reserved_fetch_ff <= nxt_pc >= pc_seq_pkg::PC_RESERVED_LO;
      end
   end

   a_reset_vector: assert property (
      @(posedge clk_sys) $rose(rst_b) |-> pc_ff == pc_seq_pkg::VEC_RESET)
      else $error("pc not at reset vector after reset");

   a_soft_vector: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && soft_int_take && !hw_int_take |=> pc_ff == pc_seq_pkg::VEC_SOFT_INT)
      else $error("software interrupt vector wrong");

   a_hw_vector: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && hw_int_take |=> pc_ff == pc_seq_pkg::VEC_HW_INT)
      else $error("hardware interrupt vector wrong");

   a_page_window: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_JUMP_IN_PAGE
      |=> pc_ff[9:8] == $past(pc_ff[9:8]) && pc_ff[7:0] == $past(flow_req.target[7:0]))
      else $error("in-page jump left its window");

   a_jump_range: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_JUMP
      |=> pc_ff == {$past(pc_ff[9]), $past(flow_req.target[8:0])})
      else $error("jump target outside range");

   a_long_reach: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_LONG_JUMP |=> pc_ff == $past(flow_req.target))
      else $error("long jump target wrong");

   a_call_return: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_LONG_CALL
      |=> stack_ptr_ff == $past(stack_ptr_ff) + 3'h1
      && stack_mem[$past(stack_ptr_ff)] == $past(pc_inc))
      else $error("call did not push next address");

   a_pop_top: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_RETURN
      |=> pc_ff == $past(stack_mem[top_idx]) && stack_ptr_ff == $past(top_idx))
      else $error("return did not pop stack top");

   a_branch_bubble: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && redirect && !bubble_ff |=> bubble_ff && flush_ff)
      else $error("taken branch did not take two cycles");

   // Companion checks: each branch class, both interrupt pushes, idle, wrap
   a_soft_push: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && soft_int_take && !hw_int_take
      |=> stack_ptr_ff == $past(stack_ptr_ff) + 3'h1
      && stack_mem[$past(stack_ptr_ff)] == $past(pc_inc))
      else $error("software interrupt did not push next address");

   a_hw_push: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && hw_int_take
      |=> stack_ptr_ff == $past(stack_ptr_ff) + 3'h1
      && stack_mem[$past(stack_ptr_ff)] == $past(pc_inc))
      else $error("hardware interrupt did not push next address");

   a_short_call: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_SHORT_CALL
      |=> pc_ff[9:8] == $past(pc_ff[9:8]) && pc_ff[7:0] == $past(flow_req.target[7:0]))
      else $error("short call left its window");

   a_page_call: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_CALL_IN_PAGE
      |=> pc_ff[9:8] == $past(pc_ff[9:8]) && pc_ff[7:0] == $past(flow_req.target[7:0]))
      else $error("in-page call left its window");

   a_long_call: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_LONG_CALL
      |=> pc_ff == $past(flow_req.target) && stack_ptr_ff == $past(stack_ptr_ff) + 3'h1)
      else $error("long call target wrong");

   a_literal_pop: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_RETURN_WITH_LITERAL
      |=> pc_ff == $past(stack_mem[top_idx]) && stack_ptr_ff == $past(top_idx))
      else $error("literal return did not pop stack top");

   a_interrupt_pop: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_RETURN_FROM_INTERRUPT
      |=> pc_ff == $past(stack_mem[top_idx]) && stack_ptr_ff == $past(top_idx))
      else $error("interrupt return did not pop stack top");

   a_fetch_follows: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      fetch_addr_ff == pc_ff)
      else $error("fetch address differs from program counter");

   a_plain_step: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !redirect |=> pc_ff == $past(pc_inc) && !flush_ff)
      else $error("plain instruction did not step by one");

   a_bubble_ends: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && bubble_ff |=> !bubble_ff && !flush_ff)
      else $error("branch took more than two cycles");

   a_hold_idle: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !cycle_en |=> $stable(pc_ff) && $stable(stack_ptr_ff) && $stable(flush_ff))
      else $error("state moved without cycle enable");

   a_reserved_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reserved_fetch_ff == (fetch_addr_ff >= pc_seq_pkg::PC_RESERVED_LO))
      else $error("reserved fetch flag wrong");

   a_rolling_words: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !redirect && pc_ff == pc_seq_pkg::ROLLING_LO
      |=> pc_ff == pc_seq_pkg::ROLLING_LO + pc_seq_pkg::PC_STEP)
      else $error("rolling-code word not fetched in order");

   a_stack_wrap: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && do_push && stack_ptr_ff == '1 |=> stack_ptr_ff == '0)
      else $error("stack pointer did not wrap");

   a_skip_taken: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && flow_req.op == pc_seq_pkg::OP_SKIP && flow_req.skip_taken
      |=> flush_ff && pc_ff == $past(pc_inc))
      else $error("taken skip did not flush");

   a_jump_no_push: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      cycle_en && !hw_int_take && !soft_int_take && !bubble_ff
      && (flow_req.op == pc_seq_pkg::OP_JUMP || flow_req.op == pc_seq_pkg::OP_LONG_JUMP
      || flow_req.op == pc_seq_pkg::OP_JUMP_IN_PAGE)
      |=> $stable(stack_ptr_ff))
      else $error("jump touched the stack");
endmodule : program_counter_sequencer

// ==== pc_seq_pkg.sv ====
package pc_seq_pkg;
   localparam int PC_W = 10;
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam logic [9:0] VEC_RESET = 10'h000;
   localparam logic [9:0] VEC_SOFT_INT = 10'h001;
   localparam logic [9:0] VEC_HW_INT = 10'h008;
   localparam logic [9:0] PC_STEP = 10'h001;
   // Target field widths per branch class
   localparam int SHORT_W = 8;
   localparam int JUMP_W = 9;
   localparam logic [9:0] PC_RESERVED_LO = 10'h3FE;
   localparam logic [9:0] ROLLING_LO = 10'h00E;

   typedef enum logic [3:0] {
      OP_NONE,
      OP_SHORT_CALL,
      OP_JUMP_IN_PAGE,
      OP_CALL_IN_PAGE,
      OP_JUMP,
      OP_LONG_CALL,
      OP_LONG_JUMP,
      OP_RETURN,
      OP_RETURN_WITH_LITERAL,
      OP_RETURN_FROM_INTERRUPT,
      OP_SKIP
   } flow_op_t;

   typedef struct packed {
      flow_op_t op;
      logic [9:0] target;
      logic skip_taken;
   } flow_req_t;
endpackage : pc_seq_pkg

// ==== prog_store_model.sv ====
`timescale 1ns/10ps
module prog_store_model (
   input wire logic [9:0] fetch_addr,
   output pc_seq_pkg::flow_req_t flow_req
);
   // Words 0x3FE-0x3FF are never loaded, so they stay idle
   pc_seq_pkg::flow_req_t mem [1024];
   initial begin
      foreach (mem[i]) mem[i] = '{pc_seq_pkg::OP_NONE, 10'h000, 1'h0};
   end
   task put(input logic [9:0] a, input pc_seq_pkg::flow_op_t op, input logic [9:0] t);
      mem[a] = '{op, t, op == pc_seq_pkg::OP_SKIP};
   endtask : put
   assign flow_req = mem[fetch_addr];
endmodule : prog_store_model

// ==== program_counter_sequencer_bench.sv ====
`timescale 1ns/10ps
module program_counter_sequencer_bench;
   logic clk_sys = 1'h0;
   logic rst_b = 1'h0;
   logic cycle_en = 1'h1;
   logic soft_int_take = 1'h0;
   logic hw_int_take = 1'h0;
   pc_seq_pkg::flow_req_t flow_req;
   logic [9:0] fetch_addr_ff;
   logic flush_ff;
   logic [2:0] stack_ptr_ff;
   logic reserved_fetch_ff;
   int failures = 0;
   int checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   program_counter_sequencer dut (.clk_sys(clk_sys), .rst_b(rst_b), .cycle_en(cycle_en),
      .flow_req(flow_req), .soft_int_take(soft_int_take), .hw_int_take(hw_int_take),
      .fetch_addr_ff(fetch_addr_ff), .flush_ff(flush_ff), .stack_ptr_ff(stack_ptr_ff),
      .reserved_fetch_ff(reserved_fetch_ff));
   prog_store_model pm (.fetch_addr(fetch_addr_ff), .flow_req(flow_req));
   task check(input logic [14:0] seen, input logic [14:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("ERROR %0t: seen %h want %h", $time, seen, want);
      end
   endtask : check
   // Interrupt pulses last exactly one taken edge
   task step(input logic s, input logic h, input logic [9:0] a, input logic [2:0] p,
      input logic f);
      soft_int_take = s;
      hw_int_take = h;
      @(posedge clk_sys);
      @(negedge clk_sys);
      soft_int_take = 1'h0;
      hw_int_take = 1'h0;
      check({reserved_fetch_ff, fetch_addr_ff, p, flush_ff}, {1'h0, a, p, f});
      check({12'h000, stack_ptr_ff}, {12'h000, p});
   endtask : step
   task t_reset;
      // Let the model clear its words first
      @(negedge clk_sys);
      pm.put(10'h000, pc_seq_pkg::OP_LONG_CALL, 10'h3A5);
      pm.put(10'h3A6, pc_seq_pkg::OP_RETURN_WITH_LITERAL, 10'h000);
      pm.put(10'h002, pc_seq_pkg::OP_JUMP, 10'h2F7);
      pm.put(10'h0F8, pc_seq_pkg::OP_JUMP_IN_PAGE, 10'h3C4);
      pm.put(10'h0C5, pc_seq_pkg::OP_CALL_IN_PAGE, 10'h155);
      pm.put(10'h056, pc_seq_pkg::OP_SHORT_CALL, 10'h2E0);
      pm.put(10'h0E1, pc_seq_pkg::OP_RETURN_FROM_INTERRUPT, 10'h000);
      pm.put(10'h058, pc_seq_pkg::OP_RETURN, 10'h000);
      pm.put(10'h0C7, pc_seq_pkg::OP_LONG_JUMP, 10'h00D);
      pm.put(10'h010, pc_seq_pkg::OP_SKIP, 10'h000);
      pm.put(10'h009, pc_seq_pkg::OP_RETURN_FROM_INTERRUPT, 10'h000);
      repeat (19) @(negedge clk_sys);
      check({1'h0, fetch_addr_ff, stack_ptr_ff, flush_ff}, 15'h0000);
      rst_b = 1'h1;
      $display("reset test done");
   endtask : t_reset
   task t_branches;
      step(0, 0, 10'h3A5, 3'h1, 1);
      step(0, 0, 10'h3A6, 3'h1, 0);
      step(0, 0, 10'h001, 3'h0, 1);
      step(0, 0, 10'h002, 3'h0, 0);
      step(0, 0, 10'h0F7, 3'h0, 1);
      step(0, 0, 10'h0F8, 3'h0, 0);
      step(0, 0, 10'h0C4, 3'h0, 1);
      step(0, 0, 10'h0C5, 3'h0, 0);
      step(0, 0, 10'h055, 3'h1, 1);
      step(0, 0, 10'h056, 3'h1, 0);
      step(0, 0, 10'h0E0, 3'h2, 1);
      step(0, 0, 10'h0E1, 3'h2, 0);
      step(0, 0, 10'h057, 3'h1, 1);
      step(0, 0, 10'h058, 3'h1, 0);
      step(0, 0, 10'h0C6, 3'h0, 1);
      step(0, 0, 10'h0C7, 3'h0, 0);
      step(0, 0, 10'h00D, 3'h0, 1);
      step(0, 0, 10'h00E, 3'h0, 0);
      cycle_en = 1'h0;
      step(0, 0, 10'h00E, 3'h0, 0);
      cycle_en = 1'h1;
      step(0, 0, 10'h00F, 3'h0, 0);
      step(0, 0, 10'h010, 3'h0, 0);
      $display("branch test done");
   endtask : t_branches
   task t_skip_int;
      step(0, 0, 10'h011, 3'h0, 1);
      step(0, 0, 10'h012, 3'h0, 0);
      step(0, 1, 10'h008, 3'h1, 1);
      step(0, 0, 10'h009, 3'h1, 0);
      step(0, 0, 10'h013, 3'h0, 1);
      step(0, 0, 10'h014, 3'h0, 0);
      step(1, 1, 10'h008, 3'h1, 1);
      step(0, 0, 10'h009, 3'h1, 0);
      step(0, 0, 10'h015, 3'h0, 1);
      step(0, 0, 10'h016, 3'h0, 0);
      step(1, 0, 10'h001, 3'h1, 1);
      $display("skip and interrupt test done");
   endtask : t_skip_int
   task t_reserved;
      pm.put(10'h002, pc_seq_pkg::OP_LONG_JUMP, 10'h3FD);
      step(0, 0, 10'h002, 3'h1, 0);
      step(0, 0, 10'h3FD, 3'h1, 1);
      @(posedge clk_sys);
      @(negedge clk_sys);
      check({4'h0, reserved_fetch_ff, fetch_addr_ff}, {5'h01, 10'h3FE});
      @(posedge clk_sys);
      @(negedge clk_sys);
      check({4'h0, reserved_fetch_ff, fetch_addr_ff}, {5'h01, 10'h3FF});
      rst_b = 1'h0;
      #1;
      check({reserved_fetch_ff, fetch_addr_ff, stack_ptr_ff, flush_ff}, 15'h0000);
      repeat (2) @(negedge clk_sys);
      rst_b = 1'h1;
      step(0, 0, 10'h3A5, 3'h1, 1);
      $display("reserved and second reset test done");
   endtask : t_reserved
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   initial begin
      t_reset();
      t_branches();
      t_skip_int();
      t_reserved();
      close_out();
   end
endmodule : program_counter_sequencer_bench
